// *** hdl/byte_buffer_mem.sv ***
// simple dual-port buffer memory with registered read data
`timescale 1ns/1ps
module byte_buffer_mem #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 25
) (
  input wire logic clk, // system clock
  input wire logic wrEn, // write strobe
  input wire logic [ADDR_W-1:0] wrAddr, // write address
  input wire logic [DATA_W-1:0] wrData, // write data
  input wire logic [ADDR_W-1:0] rdAddr, // read address
  output logic [DATA_W-1:0] rdData // read data, one cycle after address
);
  logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];

  // write port and registered read port
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // byte_buffer_mem

// *** hdl/byte_link_params.svh ***
// register offsets, field positions, reset values and timing counts of the byte link channel
`ifndef BYTE_LINK_PARAMS_SVH
`define BYTE_LINK_PARAMS_SVH

// register byte offsets, long-word aligned
`define OFS_CONTROL 8'h00
`define OFS_INT_STATUS 8'h04
`define OFS_INT_MASK 8'h08
`define OFS_TX_DATA 8'h0c
`define OFS_RX_DATA 8'h10
`define OFS_GPIO_DIR 8'h14
`define OFS_GPIO_OUT 8'h18
`define OFS_GPIO_IN 8'h1c
`define OFS_LEVELS 8'h20
`define OFS_RX_MEM_A 8'h50
`define OFS_TX_MEM_A 8'h54
`define OFS_TX_MEM_B 8'h60
`define OFS_TX_MEM_C 8'h68
`define OFS_RX_MEM_D 8'h6c
`define OFS_TX_MEM_D 8'h70
`define OFS_TX_LOOP_CNT 8'h78
`define OFS_TX_SEQ_CMD 8'h80

// control register fields
`define CTL_TX_LOAD 0
`define CTL_TX_UNLOAD 1
`define CTL_RX_LOAD 2

// sequencer command fields
`define CMD_TEST 0
`define CMD_FRAMED 2
`define CMD_CONT 3

// interrupt source positions
`define INT_RX_OVERFLOW 0
`define INT_TX_UNDERRUN 1
`define INT_PATTERN_DONE 2
`define INT_W 3

// reset values and gpio width
`define RST_CMD 8'h00
`define RST_LOOP_CNT 8'h01
`define RST_WORD 32'h0000_0000
`define GPIO_W 12

// loop-back clock: half period in clk_sys cycles
`define LOOP_HALF_NS 30
`define SYS_PERIOD_NS 5
`define LOOP_HALF_CYC (`LOOP_HALF_NS / `SYS_PERIOD_NS)

`endif

// *** hdl/byte_link_pkg.sv ***
// types shared by the byte link channel
package byte_link_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_RUN = 3'b010,
    PH_DONE = 3'b100
  } seq_phase_t;
endpackage

// *** hdl/byte_link_sequencer_mode.sv ***
// byte link channel: transmit sequencer, receiver, gpio and interrupt logic
//
// What this block does
// - command bit 0: standard when 0, test loop when 1
// - framed mode sends header, repeated body, tail
// - framed bit clear runs buffer as plain fifo
// - framed: continuous repeats forever, otherwise once
// - fifo mode always continuous, continuous bit ignored
// - receive eight parallel data lines, one byte
// - receive qualifier is active-high byte valid
// - receiver samples on received clock falling edge
// - transmit each byte on eight data lines
// - transmit qualifier high while bytes valid
// - forwarded clock: change on rise, stable fall
// - forwarded clock derived from external reference
// - internal clock on spare loop-back output
// - twelve gpio lines, direction set by software
// - maskable sources merged into one interrupt
// - buffer segment bounds set by software
// - long-word register access by host
// - command: bit3 continuous, bit2 framed, spares
// - framed pointer: A to C, back to B, D
// - body count 8 bits, valid 1 to 255
// - fifo: address after D wraps to A
`timescale 1ns/1ps
`include "byte_link_params.svh"
module byte_link_sequencer_mode
  import byte_link_pkg::*;
#(
  parameter int ADDR_W = 25,
  parameter int LOOP_HALF = `LOOP_HALF_CYC
) (
  input wire logic clk_sys, // 200 MHz system clock
  input wire logic reset, // async reset, active high
  input wire logic [7:0] regAddr, // register byte offset
  input wire logic regWrite, // register write strobe
  input wire logic regRead, // register read strobe
  input wire logic [31:0] regWdata, // register write data
  output logic [31:0] regRdata, // register read data
  output logic regAck, // access done pulse
  input wire logic [7:0] rxByteLines, // received byte
  input wire logic rxValidQualifier, // received byte valid
  input wire logic rxLinkClock, // received link clock
  output logic [7:0] txByteLines, // transmitted byte
  output logic txValidQualifier, // transmitted byte valid
  output logic txForwardedClock, // forwarded transmit clock
  input wire logic externalClockReference, // transmit clock reference
  output logic loopbackClockOutput, // internally made clock
  input wire logic [`GPIO_W-1:0] gpioIn, // gpio pin levels
  output logic [`GPIO_W-1:0] gpioOut, // gpio drive values
  output logic [`GPIO_W-1:0] gpioOe, // gpio drive enables
  output logic intRequest // host interrupt, active high
);
  localparam int SYNC_W = 11 + `GPIO_W;

  logic [SYNC_W-1:0] syncA_q, syncB_q;
  logic rxClkD_q, refD_q, rxFall, refRise;
  logic [2:0] ctrl_q;
  logic [7:0] cmd_q, loopCnt_q;
  logic [31:0] txMemA_q, txMemB_q, txMemC_q, txMemD_q, rxMemA_q, rxMemD_q;
  logic [`INT_W-1:0] intStat_q, intMask_q, intEvent;
  logic [`GPIO_W-1:0] gpioDir_q, gpioReg_q;
  logic [ADDR_W-1:0] txA, txB, txC, txD, rxA, rxD;
  logic [ADDR_W-1:0] txWrPtr_q, txRdPtr_q, rxWrPtr_q, rxRdPtr_q, txRdPtr_d;
  logic [ADDR_W:0] txCount_q, rxCount_q, txSize, rxSize;
  logic [7:0] loopsLeft_q, loopsLeft_d;
  seq_phase_t phase_q, phase_d;
  logic framed, contMode, testMode;
  logic txWrReq, txWrEn, txWrDone_q, txAvail, txUnload;
  logic rxWrReq, rxWrEn, rxWrDone_q, rxRdReq;
  byte_t txRdData, rxRdData, rxWrData;
  logic [31:0] rdMux;
  logic [15:0] loopDiv_q;

  assign framed = cmd_q[`CMD_FRAMED];
  assign contMode = cmd_q[`CMD_CONT];
  assign testMode = cmd_q[`CMD_TEST];
  assign txA = txMemA_q[ADDR_W-1:0];
  assign txB = txMemB_q[ADDR_W-1:0];
  assign txC = txMemC_q[ADDR_W-1:0];
  assign txD = txMemD_q[ADDR_W-1:0];
  assign rxA = rxMemA_q[ADDR_W-1:0];
  assign rxD = rxMemD_q[ADDR_W-1:0];
  // inclusive segment sizes
  assign txSize = {1'b0, txD} - {1'b0, txA} + {{ADDR_W{1'b0}}, 1'b1};
  assign rxSize = {1'b0, rxD} - {1'b0, rxA} + {{ADDR_W{1'b0}}, 1'b1};

  // two-stage synchronisers for every pin input
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      syncA_q <= '0;
      syncB_q <= '0;
    end
    else
    begin
      syncA_q <= {gpioIn, externalClockReference, rxLinkClock, rxValidQualifier, rxByteLines};
      syncB_q <= syncA_q;
    end
  end

  // edge detection on the synchronised clocks
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rxClkD_q <= 1'b0;
      refD_q <= 1'b0;
    end
    else
    begin
      rxClkD_q <= syncB_q[9];
      refD_q <= syncB_q[10];
    end
  end
  assign rxFall = rxClkD_q & ~syncB_q[9];
  assign refRise = ~refD_q & syncB_q[10];

  // register writes
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ctrl_q <= 3'h0;
      cmd_q <= `RST_CMD;
      loopCnt_q <= `RST_LOOP_CNT;
      txMemA_q <= `RST_WORD;
      txMemB_q <= `RST_WORD;
      txMemC_q <= `RST_WORD;
      txMemD_q <= `RST_WORD;
      rxMemA_q <= `RST_WORD;
      rxMemD_q <= `RST_WORD;
      intMask_q <= '0;
      gpioDir_q <= '0;
      gpioReg_q <= '0;
    end
    else if (regWrite)
    begin
      unique case (regAddr)
        `OFS_CONTROL: ctrl_q <= regWdata[2:0];
        `OFS_TX_SEQ_CMD: cmd_q <= regWdata[7:0];
        `OFS_TX_LOOP_CNT: loopCnt_q <= regWdata[7:0];
        `OFS_TX_MEM_A: txMemA_q <= regWdata;
        `OFS_TX_MEM_B: txMemB_q <= regWdata;
        `OFS_TX_MEM_C: txMemC_q <= regWdata;
        `OFS_TX_MEM_D: txMemD_q <= regWdata;
        `OFS_RX_MEM_A: rxMemA_q <= regWdata;
        `OFS_RX_MEM_D: rxMemD_q <= regWdata;
        `OFS_INT_MASK: intMask_q <= regWdata[`INT_W-1:0];
        `OFS_GPIO_DIR: gpioDir_q <= regWdata[`GPIO_W-1:0];
        `OFS_GPIO_OUT: gpioReg_q <= regWdata[`GPIO_W-1:0];
        default: ;
      endcase
    end
  end

  // register read mux, unmapped offsets read zero
  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (regAddr)
      `OFS_CONTROL: rdMux = {29'h0, ctrl_q};
      `OFS_INT_STATUS: rdMux = {29'h0, intStat_q};
      `OFS_INT_MASK: rdMux = {29'h0, intMask_q};
      `OFS_RX_DATA: rdMux = {24'h0, (rxCount_q != '0) ? rxRdData : 8'h00};
      `OFS_GPIO_DIR: rdMux = {20'h0, gpioDir_q};
      `OFS_GPIO_OUT: rdMux = {20'h0, gpioReg_q};
      `OFS_GPIO_IN: rdMux = {20'h0, syncB_q[22:11]};
      `OFS_LEVELS: rdMux = {13'h0, phase_q, rxCount_q[7:0], txCount_q[7:0]};
      `OFS_TX_SEQ_CMD: rdMux = {24'h0, cmd_q};
      `OFS_TX_LOOP_CNT: rdMux = {24'h0, loopCnt_q};
      `OFS_TX_MEM_A: rdMux = txMemA_q;
      `OFS_TX_MEM_B: rdMux = txMemB_q;
      `OFS_TX_MEM_C: rdMux = txMemC_q;
      `OFS_TX_MEM_D: rdMux = txMemD_q;
      `OFS_RX_MEM_A: rdMux = rxMemA_q;
      `OFS_RX_MEM_D: rdMux = rxMemD_q;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // registered read data and access acknowledge
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      regRdata <= 32'h0000_0000;
      regAck <= 1'b0;
    end
    else
    begin
      regAck <= regWrite | regRead;
      if (regRead)
      begin
        regRdata <= rdMux;
      end
    end
  end

  // transmit buffer load from host writes
  assign txWrReq = regWrite & (regAddr == `OFS_TX_DATA) & ctrl_q[`CTL_TX_LOAD];
  assign txWrEn = txWrReq & (framed | ((txCount_q + {{ADDR_W{1'b0}}, txWrDone_q}) != txSize));
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      txWrPtr_q <= '0;
      txWrDone_q <= 1'b0;
    end
    else
    begin
      txWrDone_q <= txWrEn & ~framed;
      if (!ctrl_q[`CTL_TX_LOAD])
      begin
        txWrPtr_q <= txA;
      end
      else if (txWrEn)
      begin
        txWrPtr_q <= (txWrPtr_q == txD) ? txA : txWrPtr_q + ADDR_W'(1);
      end
    end
  end

  // data is available: fifo needs stored bytes, framed needs a running pattern
  assign txAvail = ctrl_q[`CTL_TX_UNLOAD] & (framed ? (phase_q == PH_RUN) : (txCount_q != '0));
  assign txUnload = refRise & txAvail;

  // fifo fill level of the transmit segment
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      txCount_q <= '0;
    end
    else if (framed || !ctrl_q[`CTL_TX_LOAD])
    begin
      txCount_q <= '0;
    end
    else
    begin
      txCount_q <= txCount_q + {{ADDR_W{1'b0}}, txWrDone_q}
        - {{ADDR_W{1'b0}}, txUnload};
    end
  end

  // next read pointer and pattern phase
  always_comb
  begin
    txRdPtr_d = txRdPtr_q;
    loopsLeft_d = loopsLeft_q;
    phase_d = phase_q;
    if (!ctrl_q[`CTL_TX_UNLOAD])
    begin
      txRdPtr_d = txA;
      loopsLeft_d = loopCnt_q;
      phase_d = PH_IDLE;
    end
    else if (!framed)
    begin
      if (txUnload)
      begin
        txRdPtr_d = (txRdPtr_q == txD) ? txA : txRdPtr_q + ADDR_W'(1);
      end
    end
    else
    begin
      unique case (phase_q)
        PH_IDLE: phase_d = PH_RUN;
        PH_RUN:
        begin
          if (txUnload)
          begin
            if (txRdPtr_q == txD)
            begin
              txRdPtr_d = txA;
              loopsLeft_d = loopCnt_q;
              phase_d = contMode ? PH_RUN : PH_DONE;
            end
            else if ((txRdPtr_q == txC) && (loopsLeft_q > 8'h01))
            begin
              txRdPtr_d = txB;
              loopsLeft_d = loopsLeft_q - 8'h01;
            end
            else
            begin
              txRdPtr_d = txRdPtr_q + ADDR_W'(1);
            end
          end
        end
        PH_DONE: phase_d = PH_DONE;
      endcase
    end
  end

  // read pointer and pattern state
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      txRdPtr_q <= '0;
      loopsLeft_q <= `RST_LOOP_CNT;
      phase_q <= PH_IDLE;
    end
    else
    begin
      txRdPtr_q <= txRdPtr_d;
      loopsLeft_q <= loopsLeft_d;
      phase_q <= phase_d;
    end
  end

  // transmit pins: data and qualifier switch with the forwarded rising edge
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      txByteLines <= 8'h00;
      txValidQualifier <= 1'b0;
      txForwardedClock <= 1'b0;
    end
    else
    begin
      txForwardedClock <= syncB_q[10];
      if (refRise)
      begin
        txValidQualifier <= txAvail;
        if (txAvail)
        begin
          txByteLines <= txRdData;
        end
      end
    end
  end

  byte_buffer_mem #(
    .DATA_W(8),
    .ADDR_W(ADDR_W)
  ) txBuf (
    .clk(clk_sys),
    .wrEn(txWrEn),
    .wrAddr(txWrPtr_q),
    .wrData(regWdata[7:0]),
    .rdAddr(txRdPtr_q),
    .rdData(txRdData)
  );

  // receive source: qualified pin samples, or transmit bytes in test mode
  assign rxWrReq = testMode ? txUnload : (rxFall & syncB_q[8]);
  assign rxWrData = testMode ? txRdData : syncB_q[7:0];
  assign rxWrEn = rxWrReq & ctrl_q[`CTL_RX_LOAD]
    & ((rxCount_q + {{ADDR_W{1'b0}}, rxWrDone_q}) != rxSize);
  assign rxRdReq = regRead & (regAddr == `OFS_RX_DATA) & (rxCount_q != '0);

  // receive pointers and fill level
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rxWrPtr_q <= '0;
      rxRdPtr_q <= '0;
      rxCount_q <= '0;
      rxWrDone_q <= 1'b0;
    end
    else if (!ctrl_q[`CTL_RX_LOAD])
    begin
      rxWrPtr_q <= rxA;
      rxRdPtr_q <= rxA;
      rxCount_q <= '0;
      rxWrDone_q <= 1'b0;
    end
    else
    begin
      rxWrDone_q <= rxWrEn;
      rxCount_q <= rxCount_q + {{ADDR_W{1'b0}}, rxWrDone_q} - {{ADDR_W{1'b0}}, rxRdReq};
      if (rxWrEn)
      begin
        rxWrPtr_q <= (rxWrPtr_q == rxD) ? rxA : rxWrPtr_q + ADDR_W'(1);
      end
      if (rxRdReq)
      begin
        rxRdPtr_q <= (rxRdPtr_q == rxD) ? rxA : rxRdPtr_q + ADDR_W'(1);
      end
    end
  end

  byte_buffer_mem #(
    .DATA_W(8),
    .ADDR_W(ADDR_W)
  ) rxBuf (
    .clk(clk_sys),
    .wrEn(rxWrEn),
    .wrAddr(rxWrPtr_q),
    .wrData(rxWrData),
    .rdAddr(rxRdPtr_q),
    .rdData(rxRdData)
  );

  // interrupt events
  always_comb
  begin
    intEvent = '0;
    intEvent[`INT_RX_OVERFLOW] = rxWrReq & ctrl_q[`CTL_RX_LOAD] & ~rxWrEn;
    intEvent[`INT_TX_UNDERRUN] = refRise & ctrl_q[`CTL_TX_UNLOAD] & ~framed & ~txAvail;
    intEvent[`INT_PATTERN_DONE] = (phase_q == PH_RUN) & (phase_d == PH_DONE);
  end

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      intStat_q <= '0;
      intRequest <= 1'b0;
    end
    else
    begin
      if (regWrite && (regAddr == `OFS_INT_STATUS))
      begin
        intStat_q <= (intStat_q & ~regWdata[`INT_W-1:0]) | intEvent;
      end
      else
      begin
        intStat_q <= intStat_q | intEvent;
      end
      intRequest <= |(intStat_q & intMask_q);
    end
  end

  // gpio drivers
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      gpioOut <= '0;
      gpioOe <= '0;
    end
    else
    begin
      gpioOut <= gpioReg_q;
      gpioOe <= gpioDir_q;
    end
  end

  // loop-back clock divider
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      loopDiv_q <= 16'h0000;
      loopbackClockOutput <= 1'b0;
    end
    else if (loopDiv_q == 16'(LOOP_HALF - 1))
    begin
      loopDiv_q <= 16'h0000;
      loopbackClockOutput <= ~loopbackClockOutput;
    end
    else
    begin
      loopDiv_q <= loopDiv_q + 16'h0001;
    end
  end
endmodule // byte_link_sequencer_mode

// *** tb/byte_link_partner.sv ***
// far-side equipment: reference oscillator, byte sender and byte catcher
`timescale 1ns/1ps
module byte_link_partner
  import byte_link_pkg::*;
(
  output logic externalClockReference, // free running reference
  output logic rxLinkClock, // link clock, still between frames
  output byte_t rxByteLines, // byte lines
  output logic rxValidQualifier, // byte valid
  input wire logic [7:0] txByteLines, // caught byte lines
  input wire logic txValidQualifier, // caught byte valid
  input wire logic txForwardedClock // caught clock
);
  byte_t caught[$];
  // reference with a phase unrelated to the system clock
  initial
  begin
    rxLinkClock = 1'b1;
    rxByteLines = 8'h00;
    rxValidQualifier = 1'b0;
    externalClockReference = 1'b0;
    #7.3;
    forever #32 externalClockReference = ~externalClockReference;
  end
  // one byte per 64 ns, stable around the falling edge
  task automatic sendByte(input byte_t b, input logic v);
    rxByteLines = b;
    rxValidQualifier = v;
    #32 rxLinkClock = 1'b0;
    #32 rxLinkClock = 1'b1;
  endtask
  // lines released after a frame no longer hold the last value
  task automatic endFrame();
    rxByteLines = ~rxByteLines;
    rxValidQualifier = ~rxValidQualifier;
  endtask
  // the far receiver samples on the falling forwarded clock
  always @(negedge txForwardedClock)
    if (txValidQualifier === 1'b1) caught.push_back(txByteLines);
endmodule // byte_link_partner

// *** tb/byte_link_sequencer_mode_properties.sv ***
// port assertions for the byte link channel
`timescale 1ns/1ps
`include "byte_link_params.svh"
module byte_link_checker #(
  parameter int LOOP_HALF = 6
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // async reset
  input wire logic [7:0] regAddr, // register offset
  input wire logic regWrite, // write strobe
  input wire logic regRead, // read strobe
  input wire logic [31:0] regWdata, // write data
  input wire logic [31:0] regRdata, // read data
  input wire logic regAck, // access done
  input wire logic [7:0] txByteLines, // sent byte
  input wire logic txValidQualifier, // sent byte valid
  input wire logic txForwardedClock, // forwarded clock
  input wire logic externalClockReference, // transmit reference
  input wire logic loopbackClockOutput, // loop-back clock
  input wire logic [`GPIO_W-1:0] gpioOut, // gpio values
  input wire logic [`GPIO_W-1:0] gpioOe // gpio enables
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  int lbCnt;
  logic lbSeen, lbPrev;
  // cycles since the loop-back clock last changed
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      lbCnt <= 0;
      lbSeen <= 1'b0;
      lbPrev <= 1'b0;
    end
    else
    begin
      lbPrev <= loopbackClockOutput;
      if (lbPrev != loopbackClockOutput)
      begin
        lbCnt <= 0;
        lbSeen <= 1'b1;
      end
      else
        lbCnt <= lbCnt + 1;
    end
  end
  a_ack_after_access: assert property ((regWrite || regRead) |=> regAck)
    else $error("no acknowledge after an access");
  a_ack_needs_access: assert property (!(regWrite || regRead) |=> !regAck)
    else $error("acknowledge without an access");
  a_rdata_holds_idle: assert property (!regRead |=> $stable(regRdata))
    else $error("read data moved without a read");
  a_unmapped_reads_zero: assert property (regRead && regAddr == 8'h5c |=> regRdata == 0)
    else $error("unmapped read not zero");
  a_cmd_reads_back: assert property (regWrite && regAddr == `OFS_TX_SEQ_CMD ##2
    regRead && regAddr == `OFS_TX_SEQ_CMD |=> regRdata[3:2] == $past(regWdata[3:2], 3))
    else $error("command bits not read back");
  a_tx_moves_on_rise: assert property (!$rose(txForwardedClock) |->
    $stable(txByteLines) && $stable(txValidQualifier))
    else $error("transmit lines moved off the clock rise");
  a_fwd_from_ref: assert property ($changed(txForwardedClock) |->
    txForwardedClock == $past(externalClockReference, 3))
    else $error("forwarded clock does not follow the reference");
  a_loop_half_period: assert property (lbSeen |-> lbCnt < LOOP_HALF &&
    ($changed(loopbackClockOutput) == (lbCnt == LOOP_HALF - 1)))
    else $error("loop-back clock half period wrong");
  a_gpio_dir_write: assert property (regWrite && regAddr == `OFS_GPIO_DIR ##2 1'b1 |->
    gpioOe == 12'($past(regWdata, 2)))
    else $error("gpio enables not taken from write");
  a_gpio_out_write: assert property (regWrite && regAddr == `OFS_GPIO_OUT ##2 1'b1 |->
    gpioOut == 12'($past(regWdata, 2)))
    else $error("gpio values not taken from write");
endmodule // byte_link_checker

bind byte_link_sequencer_mode byte_link_checker #(.LOOP_HALF(LOOP_HALF)) u_checker (
  .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
  .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
  .txByteLines(txByteLines), .txValidQualifier(txValidQualifier),
  .txForwardedClock(txForwardedClock), .externalClockReference(externalClockReference),
  .loopbackClockOutput(loopbackClockOutput), .gpioOut(gpioOut), .gpioOe(gpioOe));

// *** tb/tb_byte_link_sequencer_mode.sv ***
// self-checking bench for the byte link channel
`timescale 1ns/1ps
`include "byte_link_params.svh"
module tb_byte_link_sequencer_mode;
  import byte_link_pkg::*;
  logic clk_sys, reset, regWrite, regRead, regAck, txValidQualifier, txForwardedClock;
  logic rxValidQualifier, rxLinkClock, externalClockReference, loopbackClockOutput, intRequest;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, rd, v;
  byte_t rxByteLines, txByteLines, b;
  byte_t p[4];
  byte_t expq[$];
  logic [11:0] gpioIn, gpioOut, gpioOe;
  int seed = 32'hc3aa;
  int mismatches, n_tests, n;
  byte_link_sequencer_mode #(.ADDR_W(8), .LOOP_HALF(3)) dut (.clk_sys(clk_sys), .reset(reset),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
    .regRdata(regRdata), .regAck(regAck), .rxByteLines(rxByteLines),
    .rxValidQualifier(rxValidQualifier), .rxLinkClock(rxLinkClock), .txByteLines(txByteLines),
    .txValidQualifier(txValidQualifier), .txForwardedClock(txForwardedClock),
    .externalClockReference(externalClockReference), .loopbackClockOutput(loopbackClockOutput),
    .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .intRequest(intRequest));
  byte_link_partner partner (.externalClockReference(externalClockReference),
    .rxLinkClock(rxLinkClock), .rxByteLines(rxByteLines), .rxValidQualifier(rxValidQualifier),
    .txByteLines(txByteLines), .txValidQualifier(txValidQualifier),
    .txForwardedClock(txForwardedClock));
  // 200 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one register access, held until the edge that takes it
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= wr;
    regRead <= !wr;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    #1;
    chk(regAck, 1'b1, "acknowledge");
    rd = regRdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    acc(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask
  // compare caught bytes with the expected stream, whole or as a prefix
  task automatic cmpCaught(input logic exact, input string what);
    for (int i = 0; i < 4000 && partner.caught.size() < expq.size(); i++)
      @(posedge clk_sys);
    repeat (40) @(posedge clk_sys);
    if (exact || partner.caught.size() < expq.size())
      chk(partner.caught.size(), expq.size(), what);
    foreach (expq[i])
      if (i < partner.caught.size()) chk(partner.caught[i], expq[i], what);
    partner.caught.delete();
    expq.delete();
  endtask
  // header, body repeated n times, tail; reps whole patterns
  function automatic void framedPattern(input int cnt, input int reps);
    for (int r = 0; r < reps; r++)
    begin
      expq.push_back(p[0]);
      for (int k = 0; k < cnt; k++)
      begin
        expq.push_back(p[1]);
        expq.push_back(p[2]);
      end
      expq.push_back(p[3]);
    end
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // cut a hang short
  initial
  begin
    #300000;
    mismatches++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    reset = 1'b1;
    regAddr = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 32'h0;
    gpioIn = 12'h000;
    mismatches = 0;
    n_tests = 0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rdc(`OFS_TX_SEQ_CMD, 32'h00, "command reset");
    rdc(`OFS_TX_LOOP_CNT, 32'h01, "loop count reset");
    rdc(8'h5c, 32'h0, "unmapped read");
    rdc(`OFS_INT_MASK, 32'h0, "mask reset");
    wr(`OFS_TX_SEQ_CMD, 32'h0c);
    rdc(`OFS_TX_SEQ_CMD, 32'h0c, "command readback");
    wr(`OFS_TX_SEQ_CMD, 32'h08);
    // gpio directions, values and inputs at random
    repeat (4)
    begin
      v = $random(seed);
      wr(`OFS_GPIO_DIR, v);
      wr(`OFS_GPIO_OUT, ~v);
      gpioIn <= v[27:16];
      repeat (4) @(posedge clk_sys);
      chk(gpioOe, v[11:0], "gpio enables");
      chk(gpioOut, 12'(~v), "gpio values");
      rdc(`OFS_GPIO_IN, v[27:16], "gpio inputs");
    end
    // fifo transmit, two full segments so the pointer wraps
    wr(`OFS_TX_MEM_A, 32'h00);
    wr(`OFS_TX_MEM_D, 32'h03);
    wr(`OFS_RX_MEM_A, 32'h80);
    wr(`OFS_RX_MEM_D, 32'h83);
    wr(`OFS_CONTROL, 32'h07);
    repeat (2)
    begin
      repeat (4)
      begin
        b = $random(seed);
        expq.push_back(b);
        wr(`OFS_TX_DATA, b);
      end
      cmpCaught(1'b1, "fifo stream");
    end
    rdc(`OFS_INT_STATUS, 32'h2, "underrun flag");
    wr(`OFS_INT_STATUS, 32'h2);
    // receive: a valid byte, a discarded byte, then enough valid bytes to overflow the buffer
    for (int i = 0; i < 8; i++)
    begin
      v = $random(seed);
      v[8] = (i == 1) ? 1'b0 : (i < 6) ? 1'b1 : v[8];
      if (v[8] && expq.size() < 4) expq.push_back(v[7:0]);
      partner.sendByte(v[7:0], v[8]);
    end
    partner.endFrame();
    repeat (10) @(posedge clk_sys);
    rdc(`OFS_INT_STATUS, 32'h3, "overflow flag");
    wr(`OFS_INT_MASK, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk(intRequest, 1'b1, "interrupt raised");
    wr(`OFS_INT_STATUS, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk(intRequest, 1'b0, "interrupt cleared");
    foreach (expq[i]) rdc(`OFS_RX_DATA, expq[i], "received byte");
    expq.delete();
    rdc(`OFS_RX_DATA, 32'h0, "empty receive read");
    // test mode loops each sent byte into the receive buffer
    wr(`OFS_TX_SEQ_CMD, 32'h09);
    b = $random(seed);
    expq.push_back(b);
    wr(`OFS_TX_DATA, b);
    cmpCaught(1'b1, "test mode send");
    rdc(`OFS_RX_DATA, b, "test mode loop");
    // framed pattern, once and then continuous
    for (int c = 0; c < 2; c++)
    begin
      wr(`OFS_TX_MEM_A, 32'h10);
      wr(`OFS_TX_MEM_B, 32'h11);
      wr(`OFS_TX_MEM_C, 32'h12);
      wr(`OFS_TX_MEM_D, 32'h13);
      wr(`OFS_CONTROL, 32'h0);
      v = $random(seed);
      n = 1 + int'(v % 3);
      wr(`OFS_TX_LOOP_CNT, n);
      wr(`OFS_TX_SEQ_CMD, c ? 32'h0c : 32'h04);
      wr(`OFS_CONTROL, 32'h1);
      foreach (p[k])
      begin
        p[k] = $random(seed);
        wr(`OFS_TX_DATA, p[k]);
      end
      wr(`OFS_CONTROL, 32'h3);
      framedPattern(n, c + 1);
      cmpCaught(!c, "framed pattern");
    end
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_TX_SEQ_CMD, 32'h04);
    wr(`OFS_CONTROL, 32'h3);
    repeat (300) @(posedge clk_sys);
    acc(1'b0, `OFS_LEVELS, 32'h0);
    chk(rd[18:16], 3'b100, "pattern finished phase");
    rdc(`OFS_INT_STATUS, 32'h6, "pattern finished flag");
    report_and_stop();
  end
endmodule // tb_byte_link_sequencer_mode
